// *** gated_timer_pkg.sv ***
// constants for the gated sixteen-bit timer: register map, fields, resets
// assumes a 32-bit apb with byte addresses, one register per aligned word
package gated_timer_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  OFF_COUNT_LOW   = 8'h00;
   localparam logic [7:0]  OFF_COUNT_HIGH  = 8'h04;
   localparam logic [7:0]  OFF_TIMER_CTRL  = 8'h08;
   localparam logic [7:0]  OFF_GATE_CTRL   = 8'h0c;
   localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h10;
   localparam logic [7:0]  OFF_IRQ_MASK    = 8'h14;

   // ----------------------------------------------------------------
   // timer_control fields
   // ----------------------------------------------------------------
   localparam int          CTL_SRC_HI      = 7;
   localparam int          CTL_SRC_LO      = 6;
   localparam int          CTL_PRE_HI      = 5;
   localparam int          CTL_PRE_LO      = 4;
   localparam int          CTL_OSC_EN      = 3;
   localparam int          CTL_ASYNC       = 2;
   localparam int          CTL_ON          = 0;
   localparam logic [7:0]  CTL_RESET       = 8'h00;
   localparam logic [7:0]  CTL_WMASK       = 8'hfd;

   // ----------------------------------------------------------------
   // gate_control fields
   // ----------------------------------------------------------------
   localparam int          GCT_ENABLE      = 7;
   localparam int          GCT_POLARITY    = 6;
   localparam int          GCT_LEVEL       = 2;
   localparam logic [7:0]  GCT_RESET       = 8'h00;

   // ----------------------------------------------------------------
   // interrupt status / mask fields
   // ----------------------------------------------------------------
   localparam int          IRQ_OVERFLOW    = 0;
   localparam logic [7:0]  IRQ_RESET       = 8'h00;

   // ----------------------------------------------------------------
   // source select codes
   // ----------------------------------------------------------------
   localparam logic [1:0]  SRC_INSTR       = 2'h0;
   localparam logic [1:0]  SRC_SYSTEM      = 2'h1;
   localparam logic [1:0]  SRC_PIN_XTAL    = 2'h2;
   localparam logic [1:0]  SRC_CAP_OSC     = 2'h3;

   // ----------------------------------------------------------------
   // counts and timing
   // ----------------------------------------------------------------
   localparam int          CLK_MHZ         = 50;
   localparam logic [1:0]  INSTR_LAST_PH   = 2'h3;
   localparam logic [15:0] COUNT_MAX       = 16'hffff;
   localparam logic [15:0] COUNT_RESET     = 16'h0000;
   localparam logic [2:0]  PRE_RESET       = 3'h0;
   localparam int          NUM_IN          = 4;
   localparam int          IN_EXT          = 0;
   localparam int          IN_CAP          = 1;
   localparam int          IN_XTAL         = 2;
   localparam int          IN_GATE         = 3;

endpackage : gated_timer_pkg

// *** gated_sixteen_bit_timer.sv ***
// gated sixteen-bit timer/counter with apb register access and interrupt
// assumes one clock ref_clk; pins are asynchronous and synchronised here
`timescale 1ns/1ps

// What this block does
// - 16-bit up-counter in two byte registers; a write replaces live byte
// - off when on bit clear; gate enable chooses free-run or gated count
// - source select and oscillator enable choose the count clock
// - instruction clock source increments once per instruction cycle
// - system clock source advances four counts per instruction cycle
// - pin or capacitive oscillator counts rising edges, sync or async
// - external count needs a falling edge first after write or disable
// - prescale field divides selected clock by 1, 2, 4 or 8
// - prescaler hidden from software, cleared by any count byte write
// - oscillator enable starts crystal driver, which runs during sleep
// - async select keeps pins synchronised; it only lets external counting run in sleep
// - async external counting continues in sleep; overflow wakes cpu when its mask bit is set
// - mode switch between sync and async may lose or add one count
// - wrap from ffff to 0000 sets overflow flag, cleared by software
// - gated counting only while gate level equals gate polarity
module gated_sixteen_bit_timer
   import gated_timer_pkg::*;
(
   input  wire logic                               ref_clk,         // clock
   input  wire logic                               rstn,            // reset
   input  wire logic                               psel,            // apb
   input  wire logic                               penable,         // apb
   input  wire logic                               pwrite,          // apb
   input  wire logic [gated_timer_pkg::ADDR_W-1:0] paddr,           // apb
   input  wire logic [31:0]                        pwdata,          // apb
   output logic      [31:0]                        prdata,          // apb
   output logic                                    pready,          // apb
   output logic                                    pslverr,         // apb
   input  wire logic                               ext_count_input, // pin
   input  wire logic                               cap_osc_input,   // osc
   input  wire logic                               crystal_in,      // xtal
   output logic                                    crystal_out,     // xtal
   input  wire logic                               gate_input,      // gate
   input  wire logic                               sleep_mode,      // cpu
   output logic                                    irq,             // level
   output logic                                    wake_request,    // level
   output logic                                    overflow_pulse   // pulse
);
   import gated_timer_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [15:0]         count_ff;
   logic [7:0]          timer_control_ff;
   logic [7:0]          gate_control_ff;
   logic [7:0]          irqStatus_ff;
   logic [7:0]          irqMask_ff;
   logic [2:0]          preCnt_ff;
   logic [1:0]          phase_ff;
   logic                armed_ff;
   logic [NUM_IN-1:0]   sync1_ff;
   logic [NUM_IN-1:0]   sync2_ff;
   logic [NUM_IN-1:0]   sync3_ff;
   logic [NUM_IN-1:0]   level_ff;
   logic [NUM_IN-1:0]   prevLevel_ff;
   logic [NUM_IN-1:0]   rise;
   logic [NUM_IN-1:0]   fall;
   logic [31:0]         prdata_ff;
   logic                pslverr_ff;
   logic                irq_ff;
   logic                wake_ff;
   logic                ovfPulse_ff;
   logic                crystalOut_ff;
   logic                setupPhase;
   logic                accessPhase;
   logic                wrEn;
   logic                countWrite;
   logic [1:0]          source_select;
   logic [1:0]          prescale_select;
   logic                osc_enable;
   logic                async_select_n;
   logic                timer_on;
   logic                gate_enable;
   logic                gate_polarity;
   logic                isExternal;
   logic                extRise;
   logic                extFall;
   logic                srcTick;
   logic                gateOpen;
   logic                running;
   logic                prescaleDone;
   logic                incr;
   logic                overflow;
   logic [7:0]          nxt_irqStatus;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [2:0] div_mask(input logic [1:0] sel);
      div_mask = 3'(({2'h0, 1'b1} << sel) - 3'h1);
   endfunction : div_mask

   function automatic logic is_addr(input logic [ADDR_W-1:0] a,
                                    input logic [7:0]        off);
      is_addr = (a == off);
   endfunction : is_addr

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      is_mapped = is_addr(a, OFF_COUNT_LOW)  | is_addr(a, OFF_COUNT_HIGH) |
                  is_addr(a, OFF_TIMER_CTRL) | is_addr(a, OFF_GATE_CTRL)  |
                  is_addr(a, OFF_IRQ_STATUS) | is_addr(a, OFF_IRQ_MASK);
   endfunction : is_mapped

   // ----------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------
   assign source_select   = timer_control_ff[CTL_SRC_HI:CTL_SRC_LO];
   assign prescale_select = timer_control_ff[CTL_PRE_HI:CTL_PRE_LO];
   assign osc_enable      = timer_control_ff[CTL_OSC_EN];
   assign async_select_n  = timer_control_ff[CTL_ASYNC];
   assign timer_on        = timer_control_ff[CTL_ON];
   assign gate_enable     = gate_control_ff[GCT_ENABLE];
   assign gate_polarity   = gate_control_ff[GCT_POLARITY];

   // ----------------------------------------------------------------
   // apb slave: zero wait states, read data captured in setup
   // ----------------------------------------------------------------
   assign setupPhase  = psel & ~penable;
   assign accessPhase = psel & penable;
   assign wrEn        = accessPhase & pwrite & is_mapped(paddr);
   assign countWrite  = wrEn & (is_addr(paddr, OFF_COUNT_LOW) |
                                is_addr(paddr, OFF_COUNT_HIGH));
   assign pready      = accessPhase;
   assign prdata      = prdata_ff;
   assign pslverr     = pslverr_ff;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else if (setupPhase) begin
         pslverr_ff <= ~is_mapped(paddr);
         prdata_ff  <= 32'h0000_0000;
         if (!pwrite) begin
            unique case (1'b1)
               is_addr(paddr, OFF_COUNT_LOW):
                  prdata_ff[7:0] <= count_ff[7:0];
               is_addr(paddr, OFF_COUNT_HIGH):
                  prdata_ff[7:0] <= count_ff[15:8];
               is_addr(paddr, OFF_TIMER_CTRL):
                  prdata_ff[7:0] <= timer_control_ff;
               is_addr(paddr, OFF_GATE_CTRL): begin
                  prdata_ff[7:0]     <= gate_control_ff;
                  prdata_ff[GCT_LEVEL] <= level_ff[IN_GATE];
               end
               is_addr(paddr, OFF_IRQ_STATUS):
                  prdata_ff[7:0] <= irqStatus_ff;
               is_addr(paddr, OFF_IRQ_MASK):
                  prdata_ff[7:0] <= irqMask_ff;
               default:
                  prdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         timer_control_ff <= CTL_RESET;
      end else if (wrEn && is_addr(paddr, OFF_TIMER_CTRL)) begin
         timer_control_ff <= pwdata[7:0] & CTL_WMASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         gate_control_ff <= GCT_RESET;
      end else if (wrEn && is_addr(paddr, OFF_GATE_CTRL)) begin
         gate_control_ff <= {pwdata[GCT_ENABLE], pwdata[GCT_POLARITY],
                             6'h00};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         irqMask_ff <= IRQ_RESET;
      end else if (wrEn && is_addr(paddr, OFF_IRQ_MASK)) begin
         irqMask_ff <= {7'h00, pwdata[IRQ_OVERFLOW]};
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers: level moves once stages two and three agree
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         sync1_ff     <= '0;
         sync2_ff     <= '0;
         sync3_ff     <= '0;
         level_ff     <= '0;
         prevLevel_ff <= '0;
      end else begin
         sync1_ff     <= {gate_input, crystal_in, cap_osc_input,
                          ext_count_input};
         sync2_ff     <= sync1_ff;
         sync3_ff     <= sync2_ff;
         level_ff     <= (sync2_ff & ~(sync2_ff ^ sync3_ff)) |
                         (level_ff & (sync2_ff ^ sync3_ff));
         prevLevel_ff <= level_ff;
      end
   end

   assign rise = level_ff & ~prevLevel_ff;
   assign fall = ~level_ff & prevLevel_ff;

   // ----------------------------------------------------------------
   // crystal driver: inverting amplifier, unaffected by sleep
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         crystalOut_ff <= 1'b0;
      end else begin
         crystalOut_ff <= osc_enable & ~crystal_in;
      end
   end

   assign crystal_out = crystalOut_ff;

   // ----------------------------------------------------------------
   // clock source selection
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         phase_ff <= 2'h0;
      end else begin
         phase_ff <= phase_ff + 2'h1;
      end
   end

   assign isExternal = source_select[1];

   always_comb begin
      extRise = 1'b0;
      extFall = 1'b0;
      if (source_select == SRC_CAP_OSC) begin
         extRise = rise[IN_CAP];
         extFall = fall[IN_CAP];
      end else if (osc_enable) begin
         extRise = rise[IN_XTAL];
         extFall = fall[IN_XTAL];
      end else begin
         extRise = rise[IN_EXT];
         extFall = fall[IN_EXT];
      end
   end

   // falling edge must be seen before the first counted rising edge
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         armed_ff <= 1'b0;
      end else if (countWrite || !timer_on) begin
         armed_ff <= 1'b0;
      end else if (isExternal && extFall) begin
         armed_ff <= 1'b1;
      end
   end

   always_comb begin
      unique case (source_select)
         SRC_SYSTEM:  srcTick = 1'b1;
         SRC_INSTR:   srcTick = (phase_ff == INSTR_LAST_PH);
         SRC_PIN_XTAL,
         SRC_CAP_OSC: srcTick = extRise & armed_ff;
      endcase
   end

   // ----------------------------------------------------------------
   // enable, gate and prescaler
   // ----------------------------------------------------------------
   assign gateOpen = (level_ff[IN_GATE] == gate_polarity);
   // sleep stops counting unless async external counting is selected
   assign running  = timer_on & (~gate_enable | gateOpen) &
                     (~sleep_mode | (isExternal & async_select_n));

   assign prescaleDone = ((preCnt_ff & div_mask(prescale_select)) ==
                          div_mask(prescale_select));

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         preCnt_ff <= PRE_RESET;
      end else if (countWrite) begin
         preCnt_ff <= PRE_RESET;
      end else if (srcTick && running) begin
         preCnt_ff <= preCnt_ff + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // counter and overflow
   // ----------------------------------------------------------------
   assign incr     = srcTick & running & prescaleDone & ~countWrite;
   assign overflow = incr & (count_ff == COUNT_MAX);

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         count_ff <= COUNT_RESET;
      end else if (wrEn && is_addr(paddr, OFF_COUNT_LOW)) begin
         count_ff[7:0] <= pwdata[7:0];
      end else if (wrEn && is_addr(paddr, OFF_COUNT_HIGH)) begin
         count_ff[15:8] <= pwdata[7:0];
      end else if (incr) begin
         count_ff <= count_ff + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ovfPulse_ff <= 1'b0;
      end else begin
         ovfPulse_ff <= overflow;
      end
   end

   assign overflow_pulse = ovfPulse_ff;

   // ----------------------------------------------------------------
   // interrupt: sticky status, write one to clear, set wins
   // ----------------------------------------------------------------
   always_comb begin
      nxt_irqStatus = irqStatus_ff;
      if (wrEn && is_addr(paddr, OFF_IRQ_STATUS)) begin
         nxt_irqStatus[IRQ_OVERFLOW] = irqStatus_ff[IRQ_OVERFLOW] &
                                       ~pwdata[IRQ_OVERFLOW];
      end
      if (overflow) begin
         nxt_irqStatus[IRQ_OVERFLOW] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         irqStatus_ff <= IRQ_RESET;
         irq_ff       <= 1'b0;
         wake_ff      <= 1'b0;
      end else begin
         irqStatus_ff <= nxt_irqStatus;
         irq_ff       <= |(nxt_irqStatus & irqMask_ff);
         wake_ff      <= sleep_mode & (|(nxt_irqStatus & irqMask_ff));
      end
   end

   assign irq          = irq_ff;
   assign wake_request = wake_ff;

endmodule : gated_sixteen_bit_timer

// *** gated_timer_properties.sv ***
// port checker for the gated sixteen-bit timer
// assumes binding onto gated_sixteen_bit_timer, one clock ref_clk
`timescale 1ns/1ps
module gated_timer_properties
   import gated_timer_pkg::*;
(
   input wire logic              ref_clk,        // clock
   input wire logic              rstn,           // reset
   input wire logic              psel,           // apb
   input wire logic              penable,        // apb
   input wire logic              pwrite,         // apb
   input wire logic [ADDR_W-1:0] paddr,          // apb
   input wire logic [31:0]       prdata,         // apb
   input wire logic              pready,         // apb
   input wire logic              pslverr,        // apb
   input wire logic              crystal_in,     // xtal
   input wire logic              crystal_out,    // xtal
   input wire logic              sleep_mode,     // cpu
   input wire logic              irq,            // level
   input wire logic              wake_request,   // level
   input wire logic              overflow_pulse  // pulse
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   wire logic maskWr = psel && penable && pwrite && paddr == OFF_IRQ_MASK;
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return a inside {OFF_COUNT_LOW, OFF_COUNT_HIGH, OFF_TIMER_CTRL,
                       OFF_GATE_CTRL, OFF_IRQ_STATUS, OFF_IRQ_MASK};
   endfunction : mapped
   sequence sSetup;
      psel && !penable;
   endsequence
   sequence sAccess;
      psel && penable;
   endsequence
   chk_ready_zero_wait: assert property (sSetup ##1 sAccess |-> pready)
      else $error("pready missing in access phase");
   chk_unmapped_err: assert property (sSetup ##1 sAccess |->
      pslverr == !mapped(paddr)) else $error("pslverr wrong");
   chk_read_upper: assert property (sSetup ##1 (sAccess and !pwrite) |->
      prdata[31:8] == '0) else $error("read upper bits set");
   chk_pulse_single: assert property (overflow_pulse |=> !overflow_pulse)
      else $error("overflow pulse longer than one cycle");
   chk_irq_cause: assert property ($rose(irq) |-> (##[0:1] overflow_pulse)
      or ($past(maskWr) || $past(maskWr, 2))) else $error("irq without cause");
   chk_wake_sleep: assert property (wake_request |-> $past(sleep_mode))
      else $error("wake request outside sleep");
   chk_reset_quiet: assert property ($rose(rstn) |-> !irq && !wake_request
      && !overflow_pulse && !crystal_out) else $error("outputs not cleared");
   chk_xtal_drive: assert property (crystal_out |-> !$past(crystal_in))
      else $error("crystal drive not inverted");
endmodule : gated_timer_properties

bind gated_sixteen_bit_timer gated_timer_properties i_props (
   .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .crystal_in(crystal_in), .crystal_out(crystal_out),
   .sleep_mode(sleep_mode), .irq(irq), .wake_request(wake_request),
   .overflow_pulse(overflow_pulse));

// *** gated_timer_ext_src.sv ***
// model of the far side: count pin, cap oscillator, crystal, gate level
// assumes the bench calls its tasks just after a rising ref_clk edge
`timescale 1ns/1ps
module gated_timer_ext_src
   import gated_timer_pkg::*;
#(
   parameter int HALF = 5
)(
   input  wire logic ref_clk, // clock
   output logic      extPin,  // count pin
   output logic      capOsc,  // cap oscillator
   output logic      xtalPin, // crystal input
   output logic      gateLvl  // gate level
);
   logic [NUM_IN-1:0] lvl = '0;
   assign extPin  = lvl[IN_EXT];
   assign capOsc  = lvl[IN_CAP];
   assign xtalPin = lvl[IN_XTAL];
   assign gateLvl = lvl[IN_GATE];
   task automatic setLevel(input int ch, input logic v);
      @(posedge ref_clk);
      lvl[ch] <= v;
   endtask : setLevel
   // each pulse falls first so the counter is armed before its rise
   task automatic pulses(input int ch, input int n);
      repeat (n) begin
         setLevel(ch, 1'b0);
         repeat (HALF) @(posedge ref_clk);
         setLevel(ch, 1'b1);
         repeat (HALF) @(posedge ref_clk);
      end
   endtask : pulses
endmodule : gated_timer_ext_src

// *** gated_sixteen_bit_timer_tb.sv ***
// self-checking bench for the gated sixteen-bit timer
// assumes the package, the design, the checker and the source model
`timescale 1ns/1ps
module gated_sixteen_bit_timer_tb;
   import gated_timer_pkg::*;
   logic        ref_clk, rstn, psel, penable, pwrite, sleepMode;
   logic [7:0]  paddr, ctl;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, errSeen, irq, wake, ovf;
   logic        extPin, capOsc, xtalPin, gateLvl;
   logic [15:0] cnt, v;
   int          fail_count = 0, n_tests = 0, seed = 66111, ovfSeen, n;
   logic [7:0]  offs [6] = '{OFF_COUNT_LOW, OFF_COUNT_HIGH, OFF_TIMER_CTRL,
                             OFF_GATE_CTRL, OFF_IRQ_STATUS, OFF_IRQ_MASK};
   logic [7:0]  extCtl [3] = '{8'h81, 8'hc1, 8'h89};
   int          extCh [3] = '{IN_EXT, IN_CAP, IN_XTAL};
   gated_sixteen_bit_timer i_dut (.ref_clk(ref_clk), .rstn(rstn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_count_input(extPin), .cap_osc_input(capOsc),
      .crystal_in(xtalPin), .crystal_out(), .gate_input(gateLvl),
      .sleep_mode(sleepMode), .irq(irq), .wake_request(wake),
      .overflow_pulse(ovf));
   gated_timer_ext_src i_src (.ref_clk(ref_clk), .extPin(extPin),
      .capOsc(capOsc), .xtalPin(xtalPin), .gateLvl(gateLvl));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (ovf === 1'b1) ovfSeen++;
   // ----------------------------------------------------------------
   // tasks and expectations
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   task automatic setCount(input logic [15:0] c);
      apb(1'b1, OFF_COUNT_LOW, {24'h0, c[7:0]});
      apb(1'b1, OFF_COUNT_HIGH, {24'h0, c[15:8]});
   endtask : setCount
   task automatic getCount(output logic [15:0] c);
      apb(1'b0, OFF_COUNT_HIGH, 32'h0);
      c[15:8] = rd[7:0];
      apb(1'b0, OFF_COUNT_LOW, 32'h0);
      c[7:0] = rd[7:0];
   endtask : getCount
   task automatic runFor(input logic [7:0] c, input int k);
      apb(1'b1, OFF_TIMER_CTRL, {24'h0, c});
      repeat (k) @(posedge ref_clk);
      apb(1'b1, OFF_TIMER_CTRL, 32'h0);
   endtask : runFor
   // on for k waits plus three edges of the two writes
   function automatic logic [15:0] expTicks(input logic [7:0] c, input int k);
      int div;
      div = (c[7:6] == SRC_INSTR) ? 4 : 1;
      return 16'((k + 3) / (div << c[5:4]));
   endfunction : expTicks
   function automatic logic near(input logic [15:0] a, input logic [15:0] b);
      logic [15:0] d;
      d = a - b;
      return d inside {16'h0000, 16'h0001, 16'hffff};
   endfunction : near
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test
   initial begin
      repeat (30000) @(posedge ref_clk);
      fail_count++;
      finish_test();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {rstn, psel, penable, pwrite, sleepMode} = 5'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      foreach (offs[i]) begin
         apb(1'b0, offs[i], 32'h0);
         check(rd, 32'h0);
      end
      apb(1'b0, 8'h18, 32'h0);
      check(errSeen, 1'b1);
      v = 16'($random(seed));
      setCount(v);
      repeat (20) @(posedge ref_clk);
      getCount(cnt);
      check(cnt, v);
      $display("test reset and readback done");
      for (int i = 0; i < 8; i++) begin
         ctl = {(i < 4) ? SRC_INSTR : SRC_SYSTEM, 2'(i), 4'h1};
         n = 40 + ($random(seed) & 127);
         setCount(16'h0);
         runFor(ctl, n);
         getCount(cnt);
         check(near(cnt, expTicks(ctl, n)), 1'b1);
      end
      $display("test internal sources done");
      for (int g = 0; g < 4; g++) begin
         apb(1'b1, OFF_GATE_CTRL, {24'h0, 1'b1, g[1], 6'h0});
         i_src.setLevel(IN_GATE, g[0]);
         repeat (8) @(posedge ref_clk);
         apb(1'b0, OFF_GATE_CTRL, 32'h0);
         check(rd[GCT_LEVEL], g[0]);
         setCount(16'h0);
         runFor(8'h41, 20);
         getCount(cnt);
         check(near(cnt, (g[1] == g[0]) ? 16'h0017 : 16'h0), 1'b1);
      end
      apb(1'b1, OFF_GATE_CTRL, 32'h0);
      $display("test gate done");
      for (int k = 0; k < 3; k++) begin
         i_src.setLevel(extCh[k], 1'b0);
         setCount(16'h0);
         apb(1'b1, OFF_TIMER_CTRL, {24'h0, extCtl[k] & 8'hfe});
         repeat (20) @(posedge ref_clk);
         apb(1'b1, OFF_TIMER_CTRL, {24'h0, extCtl[k]});
         i_src.setLevel(extCh[k], 1'b1);
         repeat (8) @(posedge ref_clk);
         n = 1 + ($random(seed) & 7);
         i_src.pulses(extCh[k], n);
         repeat (8) @(posedge ref_clk);
         apb(1'b1, OFF_TIMER_CTRL, 32'h0);
         getCount(cnt);
         check(cnt, 16'(n));
      end
      $display("test external sources done");
      ovfSeen = 0;
      setCount(16'hfff0);
      apb(1'b1, OFF_IRQ_MASK, 32'h1);
      runFor(8'h41, 30);
      getCount(cnt);
      check(near(cnt, 16'h0011), 1'b1);
      check(ovfSeen, 1);
      check(irq, 1'b1);
      apb(1'b1, OFF_IRQ_MASK, 32'h0);
      // irq follows the mask one edge after the write lands
      @(posedge ref_clk);
      check(irq, 1'b0);
      apb(1'b1, OFF_IRQ_MASK, 32'h1);
      @(posedge ref_clk);
      check(irq, 1'b1);
      apb(1'b1, OFF_IRQ_STATUS, 32'h1);
      check(irq, 1'b0);
      $display("test overflow done");
      for (int a = 0; a < 2; a++) begin
         setCount(16'hfffe);
         apb(1'b1, OFF_TIMER_CTRL, a ? 32'h85 : 32'h81);
         sleepMode <= 1'b1;
         i_src.pulses(IN_EXT, 3);
         repeat (8) @(posedge ref_clk);
         check(wake, a[0]);
         sleepMode <= 1'b0;
         apb(1'b1, OFF_TIMER_CTRL, 32'h0);
         getCount(cnt);
         check(cnt, a ? 16'h0001 : 16'hfffe);
         apb(1'b1, OFF_IRQ_STATUS, 32'h1);
      end
      $display("test sleep done");
      finish_test();
   end
endmodule : gated_sixteen_bit_timer_tb
